//--- hw/brake_seq_pkg.sv
// Package with register map, field layout and timing constants of the brake sequencer.
package brake_seq_pkg;
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_LEVEL    = 8'h04;
    localparam logic [7:0]  ADDR_DELAY    = 8'h08;
    localparam logic [7:0]  ADDR_TIME     = 8'h0C;
    localparam logic [7:0]  ADDR_FULL_LOAD = 8'h10;
    localparam logic [7:0]  ADDR_PERMIT   = 8'h14;
    localparam logic [7:0]  ADDR_INHIBIT  = 8'h18;
    localparam logic [7:0]  ADDR_STATUS   = 8'h1C;
    localparam logic [7:0]  ADDR_OVERLOAD = 8'h20;
    localparam int CTRL_DC_STOP   = 0;
    localparam int CTRL_HEAVY     = 1;
    localparam int CTRL_HALL      = 2;
    localparam int ST_STATE_LSB   = 0;
    localparam int ST_RELAY       = 4;
    localparam int ST_CURRENT     = 5;
    localparam int ST_ABORTED     = 6;
    // Decay delay is 400 ms plus 3.9 ms per ampere of full load current.
    // A straight line keeps the divider cheap and stays near every rated point.
    localparam int DECAY_BASE_MS  = 400;
    localparam int DECAY_US_PER_A = 3900;
    localparam int CLK_MHZ        = 200;
    localparam int MS_NS          = 1000000;
    localparam int CLK_NS         = 5;
    localparam int TICK_CYCLES    = MS_NS / CLK_NS;
    // Overload weights in eighths for duty and feedback source.
    localparam logic [3:0] OVLD_W_STD   = 4'h8;
    localparam logic [3:0] OVLD_W_HEAVY = 4'hC;
    localparam logic [3:0] OVLD_W_HALL  = 4'h1;
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_RUN    = 3'b001,
        ST_DELAY  = 3'b010,
        ST_BRAKE  = 3'b011,
        ST_DECAY  = 3'b100
    } brake_state_e;
endpackage : brake_seq_pkg

//--- hw/ms_tick.sv
// Millisecond enable pulse divider.
`timescale 1ns/1ps
module ms_tick #(
    parameter int CYCLES = brake_seq_pkg::TICK_CYCLES
) (
    input  wire logic clk,
    input  wire logic rstSync_n,
    output logic      tick
);
    import brake_seq_pkg::*;
    logic [19:0] count;
    logic [19:0] next_count;
    always_comb begin
        next_count = count + 20'h00001;
        if (count == 20'(CYCLES - 1)) begin
            next_count = 20'h00000;
        end
    end
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            count <= 20'h00000;
        end else begin
            count <= next_count;
        end
    end
    assign tick = (count == 20'(CYCLES - 1));
endmodule : ms_tick

//--- hw/dc_injection_brake_sequencer.sv
// DC injection brake sequencer with APB register access.
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
module dc_injection_brake_sequencer #(
    parameter int TICK_CYCLES = brake_seq_pkg::TICK_CYCLES,
    parameter int DIN_WIDTH   = 8
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    input  wire logic                 runCmd,
    input  wire logic [DIN_WIDTH-1:0] digitalIn,
    input  wire logic [15:0]          motorCurrent,
    output logic                      brakeRelay,
    output logic                      brakeCurrentOn,
    output logic [15:0]               brakeLevel,
    output logic [31:0]               overloadAccum
);
    import brake_seq_pkg::*;

    logic rstMeta_n;
    logic rstSync_n;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_n <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta_n <= 1'b1;
            rstSync_n <= rstMeta_n;
        end
    end

    logic tick;
    ms_tick #(.CYCLES(TICK_CYCLES)) u_tick (
        .clk       (clk),
        .rstSync_n (rstSync_n),
        .tick      (tick)
    );

    // Configuration registers.
    logic [2:0]           ctrl;
    logic [15:0]          level;
    logic [15:0]          delayMs;
    logic [15:0]          timeMs;
    logic [15:0]          motor_rated_full_load_current;
    logic [DIN_WIDTH-1:0] permitMask;
    logic [DIN_WIDTH-1:0] inhibitMask;
    logic [2:0]           next_ctrl;
    logic [15:0]          next_level;
    logic [15:0]          next_delayMs;
    logic [15:0]          next_timeMs;
    logic [15:0]          next_motor_rated_full_load_current;
    logic [DIN_WIDTH-1:0] next_permitMask;
    logic [DIN_WIDTH-1:0] next_inhibitMask;

    logic writeEn;
    logic readSetup;
    assign writeEn   = psel && penable && pwrite;
    assign readSetup = psel && !penable && !pwrite;
    assign pready  = 1'b1;

    always_comb begin
        next_ctrl        = ctrl;
        next_level       = level;
        next_delayMs     = delayMs;
        next_timeMs      = timeMs;
        next_motor_rated_full_load_current = motor_rated_full_load_current;
        next_permitMask  = permitMask;
        next_inhibitMask = inhibitMask;
        if (writeEn) begin
            if (paddr == ADDR_CTRL) begin
                next_ctrl = pwdata[2:0];
            end else if (paddr == ADDR_LEVEL) begin
                next_level = pwdata[15:0];
            end else if (paddr == ADDR_DELAY) begin
                next_delayMs = pwdata[15:0];
            end else if (paddr == ADDR_TIME) begin
                next_timeMs = pwdata[15:0];
            end else if (paddr == ADDR_FULL_LOAD) begin
                next_motor_rated_full_load_current = pwdata[15:0];
            end else if (paddr == ADDR_PERMIT) begin
                next_permitMask = pwdata[DIN_WIDTH-1:0];
            end else if (paddr == ADDR_INHIBIT) begin
                next_inhibitMask = pwdata[DIN_WIDTH-1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            ctrl                          <= 3'h0;
            level                         <= 16'h0000;
            delayMs                       <= 16'h0000;
            timeMs                        <= 16'h0000;
            motor_rated_full_load_current <= 16'h0000;
            permitMask                    <= '0;
            inhibitMask                   <= '0;
        end else begin
            ctrl                          <= next_ctrl;
            level                         <= next_level;
            delayMs                       <= next_delayMs;
            timeMs                        <= next_timeMs;
            motor_rated_full_load_current <=
                next_motor_rated_full_load_current;
            permitMask                    <= next_permitMask;
            inhibitMask                   <= next_inhibitMask;
        end
    end

    // Braking is allowed while every permit input is on and no inhibit is.
    logic brakeAllowed;
    assign brakeAllowed = ((digitalIn & permitMask) == permitMask)
                       && ((digitalIn & inhibitMask) == '0);

    // Decay time in milliseconds grows linearly with full load current.
    logic [15:0] decayMs;
    logic [31:0] decayProd;
    assign decayProd = 32'(motor_rated_full_load_current) * 32'(DECAY_US_PER_A)
                     / 32'h000003E8 + 32'(DECAY_BASE_MS);
    assign decayMs = decayProd[15:0];

    brake_state_e state;
    brake_state_e next_state;
    logic [15:0]  msCount;
    logic [15:0]  next_msCount;
    logic         aborted;
    logic         next_aborted;
    logic         runPrev;
    logic         stopEdge;
    assign stopEdge = runPrev && !runCmd;

    always_comb begin
        next_state   = state;
        next_msCount = msCount;
        next_aborted = aborted;
        case (state)
            ST_IDLE: begin
                if (runCmd) begin
                    next_state   = ST_RUN;
                    next_aborted = 1'b0;
                end
            end
            ST_RUN: begin
                if (stopEdge) begin
                    if (ctrl[CTRL_DC_STOP]) begin
                        next_state   = ST_DELAY;
                        next_msCount = 16'h0000;
                    end else begin
                        next_state = ST_IDLE;
                    end
                end
            end
            ST_DELAY: begin
                if (tick) begin
                    next_msCount = msCount + 16'h0001;
                end
                if (msCount >= delayMs) begin
                    next_state   = ST_BRAKE;
                    next_msCount = 16'h0000;
                end
            end
            ST_BRAKE: begin
                if (tick) begin
                    next_msCount = msCount + 16'h0001;
                end
                if (msCount >= timeMs) begin
                    next_state   = ST_DECAY;
                    next_msCount = 16'h0000;
                end
            end
            ST_DECAY: begin
                if (tick) begin
                    next_msCount = msCount + 16'h0001;
                end
                if (msCount >= decayMs) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if ((state == ST_DELAY || state == ST_BRAKE) && !brakeAllowed) begin
            next_state   = ST_IDLE;
            next_aborted = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state   <= ST_IDLE;
            msCount <= 16'h0000;
            aborted <= 1'b0;
            runPrev <= 1'b0;
        end else begin
            state   <= next_state;
            msCount <= next_msCount;
            aborted <= next_aborted;
            runPrev <= runCmd;
        end
    end

    // Relay, current and level outputs are registered from the next state so they track it exactly.
    logic [3:0]  ovldWeight;
    logic [31:0] next_overload;
    always_comb begin
        ovldWeight = ctrl[CTRL_HEAVY] ? OVLD_W_HEAVY : OVLD_W_STD;
        if (ctrl[CTRL_HALL]) begin
            ovldWeight = ovldWeight + OVLD_W_HALL;
        end
        next_overload = overloadAccum;
        // Running setting used in all other states, braking weighted.
        if (tick) begin
            if (state == ST_BRAKE) begin
                next_overload = overloadAccum
                              + ((32'(motorCurrent) * 32'(ovldWeight)) >> 3);
            end else begin
                next_overload = overloadAccum + 32'(motorCurrent);
            end
        end
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            brakeRelay     <= 1'b0;
            brakeCurrentOn <= 1'b0;
            brakeLevel     <= 16'h0000;
            overloadAccum  <= 32'h00000000;
        end else begin
            brakeRelay     <= (next_state == ST_DELAY)
                           || (next_state == ST_BRAKE)
                           || (next_state == ST_DECAY);
            brakeCurrentOn <= (next_state == ST_BRAKE);
            brakeLevel     <= (next_state == ST_BRAKE) ? next_level
                                                       : 16'h0000;
            overloadAccum  <= next_overload;
        end
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pslverr <= 1'b0;
            // Loaded in the setup cycle, so the word already stands when
            // the access phase completes with pready high.
            if (readSetup) begin
                prdata <= 32'h00000000;
                if (paddr == ADDR_CTRL) begin
                    prdata <= {29'h0, ctrl};
                end else if (paddr == ADDR_LEVEL) begin
                    prdata <= {16'h0, level};
                end else if (paddr == ADDR_DELAY) begin
                    prdata <= {16'h0, delayMs};
                end else if (paddr == ADDR_TIME) begin
                    prdata <= {16'h0, timeMs};
                end else if (paddr == ADDR_FULL_LOAD) begin
                    prdata <= {16'h0, motor_rated_full_load_current};
                end else if (paddr == ADDR_PERMIT) begin
                    prdata <= 32'(permitMask);
                end else if (paddr == ADDR_INHIBIT) begin
                    prdata <= 32'(inhibitMask);
                end else if (paddr == ADDR_STATUS) begin
                    prdata <= {25'h0, aborted, brakeCurrentOn, brakeRelay,
                               1'b0, state};
                end else if (paddr == ADDR_OVERLOAD) begin
                    prdata <= overloadAccum;
                end
            end
        end
    end

    a_current_in_relay: assert property (
        @(posedge clk) disable iff (!rstSync_n)
        brakeCurrentOn |-> brakeRelay)
        else $error("Brake current on without relay.");
    a_no_brake_disabled: assert property (
        @(posedge clk) disable iff (!rstSync_n)
        (state == ST_RUN && stopEdge && !ctrl[CTRL_DC_STOP]) |=> !brakeRelay)
        else $error("Relay energized with brake stop disabled.");
    a_abort_idle: assert property (
        @(posedge clk) disable iff (!rstSync_n)
        ((state == ST_DELAY || state == ST_BRAKE) && !brakeAllowed)
        |=> (state == ST_IDLE) && !brakeRelay && !brakeCurrentOn)
        else $error("Input abort did not end braking.");
    a_level_out: assert property (
        @(posedge clk) disable iff (!rstSync_n)
        brakeCurrentOn |-> brakeLevel == level)
        else $error("Brake level differs from setting.");
    a_decay_after: assert property (
        @(posedge clk) disable iff (!rstSync_n)
        (state == ST_BRAKE && next_state == ST_DECAY)
        |=> brakeRelay && !brakeCurrentOn)
        else $error("Relay dropped at brake time end.");
    a_delay_dark: assert property (
        @(posedge clk) disable iff (!rstSync_n)
        (state == ST_DELAY) |-> !brakeCurrentOn)
        else $error("Brake current flowing during brake delay.");
    a_decay_release: assert property (
        @(posedge clk) disable iff (!rstSync_n)
        (state == ST_DECAY && msCount >= decayMs)
        |=> (state == ST_IDLE) && !brakeRelay)
        else $error("Relay not released when decay interval expired.");
endmodule : dc_injection_brake_sequencer

//--- bench/brake_path_model.sv
// Behavioural braking contactor and freewheel gating card.
`timescale 1ns/1ps
module brake_path_model #(
    parameter int PICKUP = 2
) (
    input  wire logic        clk,
    input  wire logic        coil,
    input  wire logic        dcOn,
    input  wire logic [15:0] dcLevel,
    output logic             pathClosed,
    output logic [15:0]      senseCurrent
);
    int pickCount = 0;
    // The contact needs a few cycles to close, so late coil drive shows up.
    always @(posedge clk) begin
        pickCount <= !coil ? 0 : (pickCount < PICKUP ? pickCount + 1 : PICKUP);
    end
    assign pathClosed = coil && (pickCount == PICKUP);
    // Current only flows through a closed path.
    assign senseCurrent = (dcOn && pathClosed) ? dcLevel : 16'h0000;
endmodule : brake_path_model

//--- bench/testbench.sv
// Self-checking testbench of the brake sequencer.
`timescale 1ns/1ps
module testbench;
    import brake_seq_pkg::*;
    localparam int TK = 4;
    localparam int LVL = 32'h1234;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        runCmd = 1'b0;
    logic [7:0]  digitalIn = 8'h00;
    logic        pready, pslverr, brakeRelay, brakeCurrentOn, pathClosed;
    logic [31:0] prdata, overloadAccum;
    logic [15:0] brakeLevel, motorCurrent;
    int          numErrors = 0;
    int          nCompared = 0;
    int          cycles = 0;
    logic [31:0] loadStd, loadHeavy, loadHall;

    always #2.5 clk = ~clk;

    dc_injection_brake_sequencer #(.TICK_CYCLES(TK))
        i_dc_injection_brake_sequencer (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .runCmd(runCmd),
        .digitalIn(digitalIn), .motorCurrent(motorCurrent),
        .brakeRelay(brakeRelay), .brakeCurrentOn(brakeCurrentOn),
        .brakeLevel(brakeLevel), .overloadAccum(overloadAccum));

    brake_path_model i_brake_path_model (
        .clk(clk), .coil(brakeRelay), .dcOn(brakeCurrentOn),
        .dcLevel(brakeLevel), .pathClosed(pathClosed),
        .senseCurrent(motorCurrent));

    task automatic print_verdict();
        $display("Compared %0d, mismatches %0d", nCompared, numErrors);
        if (numErrors == 0 && nCompared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            numErrors++;
            print_verdict();
        end
    end

    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        nCompared++;
        if (g !== e) begin
            numErrors++;
            $display("Error %s expected %0h seen %0h", nm, e, g);
        end
    endtask : check

    task automatic checkRange(input string nm, input int lo, input int hi,
                              input logic [31:0] g);
        nCompared++;
        if ($isunknown(g) || g < lo || g > hi) begin
            numErrors++;
            $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask : checkRange

    task automatic apbXfer(input logic wr, input logic [7:0] a,
                           input logic [31:0] wd, output logic [31:0] rd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apbXfer

    task automatic apbWrite(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        apbXfer(1'b1, a, d, unused);
    endtask : apbWrite

    // Counts falling edges until the chosen output reaches a level.
    task automatic waitLvl(input bit cur, input logic v, output int n);
        n = 0;
        while (((cur ? brakeCurrentOn : brakeRelay) !== v) && n < 5000) begin
            @(negedge clk);
            n++;
        end
    endtask : waitLvl

    task automatic startStop(input logic [31:0] ctrl);
        apbWrite(ADDR_CTRL, ctrl);
        runCmd <= 1'b1;
        repeat (3) @(posedge clk);
        runCmd <= 1'b0;
    endtask : startStop

    task automatic testNoDc();
        logic [31:0] d;
        startStop(32'h0);
        repeat (40) @(posedge clk);
        check("relay", 1'b0, brakeRelay);
        check("current", 1'b0, brakeCurrentOn);
        apbXfer(1'b0, 8'h40, 32'h0, d);
        check("unmapped read", 32'h0, d);
        $display("Test coast stop done");
    endtask : testNoDc

    task automatic testFull(input logic [31:0] ctrl, output logic [31:0] dl);
        int n;
        logic [31:0] load0, d;
        startStop(ctrl);
        waitLvl(0, 1'b1, n);
        checkRange("relay rise", 0, 4, n);
        waitLvl(1, 1'b1, n);
        checkRange("brake delay", 4 * TK, 6 * TK + 3, n);
        check("path closed", 1'b1, pathClosed);
        check("level", LVL, {16'h0, brakeLevel});
        load0 = overloadAccum;
        waitLvl(1, 1'b0, n);
        checkRange("brake time", 4 * TK, 6 * TK + 3, n);
        dl = overloadAccum - load0;
        check("relay held", 1'b1, brakeRelay);
        waitLvl(0, 1'b0, n);
        checkRange("decay", 789 * TK, 791 * TK + 3, n);
        @(posedge clk);
        apbXfer(1'b0, ADDR_STATUS, 32'h0, d);
        check("state", 32'h0, {29'h0, d[2:0]});
        $display("Test full brake ctrl %0h done", ctrl);
    endtask : testFull

    // Flips one input in the delay, or while current flows when cur is set,
    // and expects a clean abort.
    task automatic testAbort(input logic [7:0] a, input logic [7:0] m,
                             input logic [7:0] on, input logic [7:0] off,
                             input bit cur);
        int n;
        logic [31:0] d;
        apbWrite(a, {24'h0, m});
        digitalIn <= on;
        startStop(32'h1);
        waitLvl(cur, 1'b1, n);
        @(posedge clk);
        digitalIn <= off;
        repeat (4) @(posedge clk);
        check("abort relay", 1'b0, brakeRelay);
        check("abort current", 1'b0, brakeCurrentOn);
        digitalIn <= on;
        repeat (60) @(posedge clk);
        check("no resume", 1'b0, brakeRelay);
        apbXfer(1'b0, ADDR_STATUS, 32'h0, d);
        check("aborted idle", 32'h40, d & 32'h47);
        apbWrite(a, 32'h0);
        $display("Test abort mask %0h done", m);
    endtask : testAbort

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        check("reset relay", 1'b0, brakeRelay);
        check("reset error", 1'b0, pslverr);
        apbWrite(ADDR_LEVEL, LVL);
        apbWrite(ADDR_DELAY, 32'h00000005);
        apbWrite(ADDR_TIME, 32'h00000005);
        apbWrite(ADDR_FULL_LOAD, 32'h00000064);
        testNoDc();
        testFull(32'h1, loadStd);
        checkRange("std overload", 4 * LVL, 6 * LVL, loadStd);
        testFull(32'h3, loadHeavy);
        check("heavy weight", 1'b1, loadHeavy > loadStd);
        testFull(32'h5, loadHall);
        check("hall weight", 1'b1, loadHall > loadStd);
        testAbort(ADDR_PERMIT, 8'h01, 8'h01, 8'h00, 1'b1);
        testAbort(ADDR_INHIBIT, 8'h80, 8'h00, 8'h80, 1'b0);
        print_verdict();
    end
endmodule : testbench
